// ==== rtl/eetw_pkg.sv ====
package eetw_pkg;
  localparam int CLK_NS = 10;
  localparam int FILT_NS = 100;
  localparam int FILT_CYC = FILT_NS / CLK_NS + 1;
  localparam int PU_MS = 1;
  localparam int PU_CYC = PU_MS * 1000000 / CLK_NS;
  localparam int WR_MS = 5;
  localparam int WR_CYC = WR_MS * 1000000 / CLK_NS;
  localparam int QUARTER_CYC = 25;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [3:0] ADDR_BYTES = 4'h2;
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CMD_START_BIT = 8;
  localparam int CMD_STOP_BIT = 9;
  localparam int CMD_READ_BIT = 10;
  localparam int CMD_NACK_BIT = 11;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RX_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_ADDR = 3'h1,
    D_ACK = 3'h3,
    D_RX = 3'h2,
    D_TX = 3'h6,
    D_MACK = 3'h7
  } eetw_dstate_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BITS = 2'h3,
    H_STOP = 2'h2
  } eetw_hstate_t;
endpackage

// ==== rtl/eetw_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface eetw_if;
  logic h_scl_out;
  logic h_scl_oe_n;
  logic h_sda_out;
  logic h_sda_oe_n;
  logic d_sda_out;
  logic d_sda_oe_n;
  logic scl;
  logic sda;
  // =====================================================
  // Wired-and lines with pull-ups.
  assign scl = h_scl_oe_n | h_scl_out;
  assign sda = (h_sda_oe_n | h_sda_out) & (d_sda_oe_n | d_sda_out);
  modport host (output h_scl_out, output h_scl_oe_n, output h_sda_out, output h_sda_oe_n, input scl, input sda);
  modport dev (output d_sda_out, output d_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

// ==== rtl/eetw_dev.sv ====
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module eetw_dev #(
  parameter int PU_CYC = eetw_pkg::PU_CYC,
  parameter int WR_CYC = eetw_pkg::WR_CYC,
  parameter bit HAS_STRAPS = 1'b1,
  parameter bit HAS_WP = 1'b1
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Two-wire bus.
  eetw_if.dev bus,
  // Straps and protection.
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic write_protect,
  // Read data source.
  input wire logic [7:0] tx_data,
  output logic tx_take,
  // Received data and status.
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic selected,
  output logic read_mode,
  output logic ready,
  output logic write_busy,
  output logic write_rejected
);
  // =====================================================
  // Elaboration checks.
  if (eetw_pkg::FILT_CYC > 15 || PU_CYC < 1 || WR_CYC < 1)
  begin : g_chk
    $error("Unsupported timing parameters.");
  end

  eetw_pkg::eetw_dstate_t state;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [1:0] line_s1;
  logic [1:0] line_s2;
  logic [1:0] line_f;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic sda_oe_n;
  logic [3:0] rx_cnt;
  logic wp_block;
  logic data_seen;
  logic launch;
  logic [31:0] pu_cnt;
  logic [31:0] wr_cnt;
  logic [2:0] strap_val;
  logic wp_val;
  logic addr_match;

  // =====================================================
  // Input synchronisers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      line_s1 <= 2'h3;
      line_s2 <= 2'h3;
    end
    else
    begin
      pin_s1 <= {write_protect, select_strap_bit2, select_strap_bit1, select_strap_bit0};
      pin_s2 <= pin_s1;
      line_s1 <= {bus.scl, bus.sda};
      line_s2 <= line_s1;
    end
  end

  // =====================================================
  // Glitch filters.
  for (genvar i = 0; i < 2; i++)
  begin : g_filt
    logic f;
    logic [3:0] cnt;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        f <= 1'b1;
        cnt <= 4'h0;
      end
      else if (line_s2[i] == f)
        cnt <= 4'h0;
      else if (cnt == 4'(eetw_pkg::FILT_CYC - 1))
      begin
        f <= line_s2[i];
        cnt <= 4'h0;
      end
      else
        cnt <= cnt + 4'h1;
    end
    assign line_f[i] = f;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= line_f[1];
      sda_d <= line_f[0];
    end
  end

  assign scl_rise = line_f[1] & ~scl_d;
  assign scl_fall = ~line_f[1] & scl_d;
  assign start_det = line_f[1] & scl_d & sda_d & ~line_f[0];
  assign stop_det = line_f[1] & scl_d & ~sda_d & line_f[0];

  assign strap_val = HAS_STRAPS ? pin_s2[2:0] : 3'h0;
  assign wp_val = HAS_WP ? pin_s2[3] : 1'b0;
  assign addr_match = shreg[7:4] == eetw_pkg::DEV_TYPE && shreg[3:1] == strap_val;

  // =====================================================
  // Power-up and write cycle timers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pu_cnt <= 32'h0;
      ready <= 1'b0;
    end
    else if (!ready)
    begin
      pu_cnt <= pu_cnt + 32'h1;
      ready <= pu_cnt == 32'(PU_CYC - 1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_cnt <= 32'h0;
      write_busy <= 1'b0;
    end
    else if (launch)
    begin
      wr_cnt <= 32'h0;
      write_busy <= 1'b1;
    end
    else if (write_busy)
    begin
      wr_cnt <= wr_cnt + 32'h1;
      write_busy <= wr_cnt != 32'(WR_CYC - 1);
    end
  end

  // =====================================================
  // Protocol engine.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= eetw_pkg::D_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      sda_oe_n <= 1'b1;
      read_mode <= 1'b0;
      rx_cnt <= 4'h0;
      wp_block <= 1'b0;
      data_seen <= 1'b0;
      launch <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      tx_take <= 1'b0;
      write_rejected <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      tx_take <= 1'b0;
      launch <= 1'b0;
      if (stop_det)
      begin
        state <= eetw_pkg::D_IDLE;
        sda_oe_n <= 1'b1;
        launch <= data_seen & ~wp_block;
        data_seen <= 1'b0;
        wp_block <= 1'b0;
      end
      else if (start_det && ready && !write_busy)
      begin
        state <= eetw_pkg::D_ADDR;
        bitcnt <= 4'h0;
        sda_oe_n <= 1'b1;
        write_rejected <= 1'b0;
      end
      else if (scl_rise && (state == eetw_pkg::D_ADDR || state == eetw_pkg::D_RX))
      begin
        shreg <= {shreg[6:0], line_f[0]};
        bitcnt <= bitcnt + 4'h1;
      end
      else if (scl_rise && state == eetw_pkg::D_MACK && line_f[0])
        state <= eetw_pkg::D_IDLE;
      else if (scl_fall)
      begin
        case (state)
          eetw_pkg::D_ADDR:
          begin
            if (bitcnt == 4'h8)
            begin
              if (addr_match)
              begin
                sda_oe_n <= 1'b0;
                read_mode <= shreg[0];
                rx_cnt <= 4'h0;
                state <= eetw_pkg::D_ACK;
              end
              else
                state <= eetw_pkg::D_IDLE;
            end
          end
          eetw_pkg::D_ACK:
          begin
            bitcnt <= 4'h0;
            if (read_mode)
            begin
              sda_oe_n <= tx_data[7];
              txsh <= {tx_data[6:0], 1'b0};
              tx_take <= 1'b1;
              bitcnt <= 4'h1;
              state <= eetw_pkg::D_TX;
            end
            else
            begin
              sda_oe_n <= 1'b1;
              if (rx_cnt == eetw_pkg::ADDR_BYTES)
                wp_block <= wp_val;
              state <= eetw_pkg::D_RX;
            end
          end
          eetw_pkg::D_RX:
          begin
            if (bitcnt == 4'h8)
            begin
              if (rx_cnt >= eetw_pkg::ADDR_BYTES && wp_block)
              begin
                write_rejected <= 1'b1;
                state <= eetw_pkg::D_IDLE;
              end
              else
              begin
                sda_oe_n <= 1'b0;
                rx_data <= shreg;
                rx_valid <= 1'b1;
                data_seen <= data_seen | (rx_cnt >= eetw_pkg::ADDR_BYTES);
                if (rx_cnt != 4'hf)
                  rx_cnt <= rx_cnt + 4'h1;
                state <= eetw_pkg::D_ACK;
              end
            end
          end
          eetw_pkg::D_TX:
          begin
            if (bitcnt == 4'h8)
            begin
              sda_oe_n <= 1'b1;
              state <= eetw_pkg::D_MACK;
            end
            else
            begin
              sda_oe_n <= txsh[7];
              txsh <= {txsh[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          eetw_pkg::D_MACK:
          begin
            sda_oe_n <= tx_data[7];
            txsh <= {tx_data[6:0], 1'b0};
            tx_take <= 1'b1;
            bitcnt <= 4'h1;
            state <= eetw_pkg::D_TX;
          end
          default:
            sda_oe_n <= 1'b1;
        endcase
      end
    end
  end

  assign selected = state != eetw_pkg::D_IDLE && state != eetw_pkg::D_ADDR;
  assign bus.d_sda_out = 1'b0;
  assign bus.d_sda_oe_n = sda_oe_n;
endmodule
`default_nettype wire

// ==== rtl/eetw_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module eetw_host #(
  parameter int QUARTER_CYC = eetw_pkg::QUARTER_CYC
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Two-wire bus.
  eetw_if.host bus,
  // AXI4-Lite write channels.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  if (QUARTER_CYC < 2 || QUARTER_CYC > 65535)
  begin : g_chk
    $error("Unsupported quarter period.");
  end

  eetw_pkg::eetw_hstate_t state;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [15:0] qcnt;
  logic tick;
  logic [1:0] phase;
  logic [3:0] bitcnt;
  logic [7:0] txb;
  logic [7:0] rxb;
  logic c_start;
  logic c_stop;
  logic c_read;
  logic c_nack;
  logic go;
  logic got_nack;
  logic scl_oe_n;
  logic sda_oe_n;
  logic sda_s1;
  logic sda_s2;
  logic busy;

  // =====================================================
  // Register slave.
  assign awready = !aw_got && !bvalid;
  assign wready = !w_got && !bvalid;
  assign arready = !rvalid;
  assign busy = go || state != eetw_pkg::H_IDLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0;
      bvalid <= 1'b0;
      bresp <= eetw_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got <= 1'b1;
        aw_a <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got <= 1'b1;
        w_d <= wdata;
      end
      if (aw_got && w_got && !bvalid)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= aw_a == eetw_pkg::CMD_OFS ? eetw_pkg::RESP_OKAY : eetw_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= eetw_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp <= araddr == eetw_pkg::STAT_OFS ? eetw_pkg::RESP_OKAY : eetw_pkg::RESP_SLVERR;
      rdata <= 32'h0;
      if (araddr == eetw_pkg::STAT_OFS)
      begin
        rdata[eetw_pkg::STAT_BUSY_BIT] <= busy;
        rdata[eetw_pkg::STAT_NACK_BIT] <= got_nack;
        rdata[eetw_pkg::STAT_RX_LSB +: 8] <= rxb;
      end
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // =====================================================
  // Quarter-period divider and data synchroniser.
  assign tick = qcnt == 16'(QUARTER_CYC - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      qcnt <= 16'h0;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      qcnt <= tick ? 16'h0 : qcnt + 16'h1;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // =====================================================
  // Bit engine.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= eetw_pkg::H_IDLE;
      phase <= 2'h0;
      bitcnt <= 4'h0;
      txb <= 8'h00;
      rxb <= 8'h00;
      c_start <= 1'b0;
      c_stop <= 1'b0;
      c_read <= 1'b0;
      c_nack <= 1'b0;
      go <= 1'b0;
      got_nack <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      if (aw_got && w_got && !bvalid && aw_a == eetw_pkg::CMD_OFS && !busy)
      begin
        txb <= w_d[7:0];
        c_start <= w_d[eetw_pkg::CMD_START_BIT];
        c_stop <= w_d[eetw_pkg::CMD_STOP_BIT];
        c_read <= w_d[eetw_pkg::CMD_READ_BIT];
        c_nack <= w_d[eetw_pkg::CMD_NACK_BIT];
        go <= 1'b1;
      end
      if (tick)
      begin
        phase <= phase + 2'h1;
        case (state)
          eetw_pkg::H_IDLE:
          begin
            phase <= 2'h0;
            if (go)
            begin
              go <= 1'b0;
              bitcnt <= 4'h0;
              state <= c_start ? eetw_pkg::H_START : eetw_pkg::H_BITS;
            end
          end
          eetw_pkg::H_START:
          begin
            case (phase)
              2'h0: sda_oe_n <= 1'b1;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b0;
              default:
              begin
                scl_oe_n <= 1'b0;
                state <= eetw_pkg::H_BITS;
              end
            endcase
          end
          eetw_pkg::H_BITS:
          begin
            case (phase)
              2'h0:
                if (bitcnt == 4'h8)
                  sda_oe_n <= c_read ? c_nack : 1'b1;
                else
                  sda_oe_n <= c_read ? 1'b1 : txb[7];
              2'h1: scl_oe_n <= 1'b1;
              2'h2:
                if (bitcnt == 4'h8)
                  got_nack <= sda_s2;
                else
                begin
                  rxb <= {rxb[6:0], sda_s2};
                  txb <= {txb[6:0], 1'b0};
                end
              default:
              begin
                scl_oe_n <= 1'b0;
                bitcnt <= bitcnt + 4'h1;
                if (bitcnt == 4'h8)
                  state <= c_stop ? eetw_pkg::H_STOP : eetw_pkg::H_IDLE;
              end
            endcase
          end
          eetw_pkg::H_STOP:
          begin
            case (phase)
              2'h0: sda_oe_n <= 1'b0;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b0;
              default:
              begin
                sda_oe_n <= 1'b1;
                state <= eetw_pkg::H_IDLE;
              end
            endcase
          end
          default: state <= eetw_pkg::H_IDLE;
        endcase
      end
    end
  end

  assign bus.h_scl_out = 1'b0;
  assign bus.h_scl_oe_n = scl_oe_n;
  assign bus.h_sda_out = 1'b0;
  assign bus.h_sda_oe_n = sda_oe_n;
endmodule
`default_nettype wire

// ==== verification/eetw_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module eetw_sva (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Host line drivers.
  input wire logic h_scl_out,
  input wire logic h_scl_oe_n,
  input wire logic h_sda_out,
  input wire logic h_sda_oe_n,
  // Device line drivers.
  input wire logic d_sda_out,
  input wire logic d_sda_oe_n,
  // Resolved lines.
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Line conditions.
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  // ==========================================================
  // Properties.
  property p_dev_od;
    d_sda_out == 1'b0;
  endproperty
  property p_host_od;
    h_sda_out == 1'b0 && h_scl_out == 1'b0;
  endproperty
  property p_dev_edge;
    $changed(d_sda_oe_n) |-> !scl && !$past(scl);
  endproperty
  property p_dev_filt;
    $fell(scl) |=> $stable(d_sda_oe_n) [*8];
  endproperty
  property p_dev_release;
    $fell(d_sda_oe_n) |-> ##[1:130] $rose(d_sda_oe_n);
  endproperty
  property p_start_free;
    s_start |-> d_sda_oe_n;
  endproperty
  property p_start_hold;
    s_start |-> ##[20:30] $fell(scl);
  endproperty
  property p_stop_idle;
    s_stop |=> (scl && sda && d_sda_oe_n) [*8];
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drove data high");
  a_host_od: assert property (p_host_od) else $error("host drove a line high");
  a_dev_edge: assert property (p_dev_edge) else $error("device data moved while clock high");
  a_dev_filt: assert property (p_dev_filt) else $error("device reacted inside filter time");
  a_dev_release: assert property (p_dev_release) else $error("device held data too long");
  a_start_free: assert property (p_start_free) else $error("device drove data at start");
  a_start_hold: assert property (p_start_hold) else $error("start not followed by clock low");
  a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
endmodule
`default_nettype wire

// ==== verification/tb_eetw.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_eetw;
  // ==========================================================
  // Bench signals.
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [2:0] straps;
  logic write_protect;
  logic [7:0] tx_data;
  logic tx_take, rx_valid, selected, read_mode, ready, write_busy, write_rejected;
  logic [7:0] rx_data;
  logic [7:0] rx_last;
  logic sel_seen;
  logic [31:0] st;
  logic [31:0] rd;
  logic [1:0] resp;
  int n_take;
  int n_mismatch;
  int n_checks;
  int n_cyc;
  localparam logic [3:0] F_START = 4'h1;
  localparam logic [3:0] F_STOP = 4'h2;
  localparam logic [3:0] F_READ = 4'h4;
  localparam logic [3:0] F_NACK = 4'h8;
  // ==========================================================
  // Design and checker.
  eetw_if bus_if();
  eetw_host #(.QUARTER_CYC(25)) i_eetw_host (.aclk(aclk), .aresetn(aresetn), .bus(bus_if),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  eetw_dev #(.PU_CYC(200), .WR_CYC(2000), .HAS_STRAPS(1'b1), .HAS_WP(1'b1)) i_eetw_dev (
    .aclk(aclk), .aresetn(aresetn), .bus(bus_if), .select_strap_bit0(straps[0]),
    .select_strap_bit1(straps[1]), .select_strap_bit2(straps[2]), .write_protect(write_protect),
    .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
    .selected(selected), .read_mode(read_mode), .ready(ready), .write_busy(write_busy),
    .write_rejected(write_rejected));
  eetw_sva i_eetw_sva (.aclk(aclk), .aresetn(aresetn), .h_scl_out(bus_if.h_scl_out),
    .h_scl_oe_n(bus_if.h_scl_oe_n), .h_sda_out(bus_if.h_sda_out), .h_sda_oe_n(bus_if.h_sda_oe_n),
    .d_sda_out(bus_if.d_sda_out), .d_sda_oe_n(bus_if.d_sda_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));
  // ==========================================================
  // Clock, monitors and timeout.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (rx_valid === 1'b1)
      rx_last <= rx_data;
    if (tx_take === 1'b1)
      n_take <= n_take + 1;
    if (selected === 1'b1)
      sel_seen <= 1'b1;
    n_cyc <= n_cyc + 1;
    if (n_cyc == 60000)
    begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end
  // ==========================================================
  // Tasks.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic op(input logic [7:0] b, input logic [3:0] f);
    axi_wr(eetw_pkg::CMD_OFS, {20'h00000, f, b}, resp);
    chk("cmd_bresp", resp, eetw_pkg::RESP_OKAY);
    st = 32'h1;
    while (st[eetw_pkg::STAT_BUSY_BIT] !== 1'b0)
      axi_rd(eetw_pkg::STAT_OFS, st, resp);
  endtask
  task automatic wr_session();
    op(8'haa, F_START);
    op(8'h00, 4'h0);
    op(8'h10, 4'h0);
    op(8'h5c, F_STOP);
  endtask
  task automatic end_of_test();
    $display("TB: checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence.
  initial
  begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    straps = 3'h5;
    write_protect = 1'b0;
    tx_data = 8'hd5;
    {n_take, n_mismatch, n_checks, n_cyc} = {32'h0, 32'h0, 32'h0, 32'h0};
    sel_seen = 1'b0;
    repeat (5) @(posedge aclk);
    chk("ready_in_reset", ready, 1'b0);
    aresetn <= 1'b1;
    repeat (100) @(posedge aclk);
    chk("ready_early", ready, 1'b0);
    repeat (120) @(posedge aclk);
    chk("ready_late", ready, 1'b1);
    wr_session();
    chk("data_ack", st[eetw_pkg::STAT_NACK_BIT], 1'b0);
    chk("rx_byte", rx_last, 8'h5c);
    chk("dir_write", read_mode, 1'b0);
    repeat (20) @(posedge aclk);
    chk("write_busy", write_busy, 1'b1);
    op(8'haa, F_START | F_STOP);
    chk("busy_nack", st[eetw_pkg::STAT_NACK_BIT], 1'b1);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("ready_reset", ready, 1'b0);
    chk("busy_reset", write_busy, 1'b0);
    aresetn <= 1'b1;
    while (write_busy !== 1'b0 || ready !== 1'b1)
      @(posedge aclk);
    sel_seen = 1'b0;
    op(8'haa, 4'h0);
    chk("nostart_nack", st[eetw_pkg::STAT_NACK_BIT], 1'b1);
    chk("nostart_sel", sel_seen, 1'b0);
    sel_seen = 1'b0;
    op(8'ha4, F_START | F_STOP);
    chk("mismatch_nack", st[eetw_pkg::STAT_NACK_BIT], 1'b1);
    chk("mismatch_sel", sel_seen, 1'b0);
    op(8'haa, F_START);
    chk("addr_ack", st[eetw_pkg::STAT_NACK_BIT], 1'b0);
    op(8'h00, 4'h0);
    n_take = 0;
    op(8'hab, F_START);
    chk("restart_ack", st[eetw_pkg::STAT_NACK_BIT], 1'b0);
    chk("dir_read", read_mode, 1'b1);
    op(8'hff, F_READ | F_NACK | F_STOP);
    chk("read_byte", st[15:8], 8'hd5);
    chk("read_take", n_take, 1);
    write_protect <= 1'b1;
    wr_session();
    chk("wp_nack", st[eetw_pkg::STAT_NACK_BIT], 1'b1);
    chk("wp_rejected", write_rejected, 1'b1);
    repeat (20) @(posedge aclk);
    chk("wp_no_busy", write_busy, 1'b0);
    axi_rd(8'h08, rd, resp);
    chk("unmapped_rresp", resp, eetw_pkg::RESP_SLVERR);
    chk("unmapped_rdata", rd, 32'h0);
    axi_wr(8'h0c, 32'h0, resp);
    chk("unmapped_bresp", resp, eetw_pkg::RESP_SLVERR);
    axi_rd(eetw_pkg::STAT_OFS, rd, resp);
    chk("status_rresp", resp, eetw_pkg::RESP_OKAY);
    chk("status_idle", rd[eetw_pkg::STAT_BUSY_BIT], 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
